// ==== valve_io_pkg.sv ====
// Package with register map, field layout and state types of the valve discrete I/O block
package valve_io_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MODE_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  localparam logic [1:0] SYNC_RST = 2'h0;

  // ****************************************************************
  // Interrupt event bits
  // ****************************************************************
  localparam int IRQ_FAULT_SET = 0;
  localparam int IRQ_FAULT_CLR = 1;
  localparam int IRQ_ENABLE_CHG = 2;
  localparam int IRQ_SET_CHG = 3;

  // Control register fields
  typedef struct packed {
    logic [1:0] f_mon_sel;
    logic [1:0] q_mon_sel;
    logic ref_fieldbus;
    logic gray_sel;
    logic fault_gpo_val;
    logic fault_as_gpo;
  } ctrl_type;

  typedef struct packed {
    logic ref_onoff;
    logic enable_as_gpi;
    logic [5:0] chan_current;
  } mode_type;

  typedef struct packed {
    logic solenoid_short;
    logic solenoid_open;
    logic ref_cable_broken;
    logic lvdt_cable_broken;
  } fault_src_type;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } wb_rsp_type;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_type;

endpackage : valve_io_pkg

// ==== valve_driver_discrete_io.sv ====
// Discrete enable, fault, parameter-set and source-select logic of the valve driver
`timescale 1ns/1ps

// What this block does
// - Enable input high lets solenoid current flow; low blocks it.
// - Enable low forces solenoid current to zero; supply stays untouched.
// - Disable inhibits only solenoid current; bus and other functions keep working.
// - Software can turn the enable input into a general-purpose input.
// - Repeat-enable output copies the current enable input state.
// - Fault output is low while any fault exists, high otherwise.
// - Faults: solenoid short or open, broken current reference, broken transducer.
// - Fault output is computed without regard to the enable input.
// - Software can turn the fault output into a general-purpose output.
// - Broken reference in current mode also disables valve operation.
// - Two select inputs pick one of four parameter sets in binary code.
// - Software can switch the set decoding from binary to Gray code.
// - Set changes take effect at any time without disable or restart.
// - Each analog channel has a software voltage or current mode with default.
// - Software can take flow and force references from the fieldbus.
// - An analog reference can be read as a two-state on-off command.
// - Monitor outputs default to primary quantity; a selector routes other signals.
// - With logic supply fitted, diagnostics keep running without solenoid power.
module valve_driver_discrete_io #(
  parameter logic [5:0] CHAN_CURRENT_DEFAULT = 6'h00
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic enable_i,
  input wire logic param_set_sel_0_i,
  input wire logic param_set_sel_1_i,
  input wire valve_io_pkg::fault_src_type fault_src_i,
  input wire logic solenoid_supply_ok_i,
  output logic solenoid_en_o,
  output logic repeat_enable_o,
  output logic fault_n_o,
  output logic [1:0] param_set_o,
  output logic enable_gpi_o,
  output logic ref_from_fieldbus_o,
  output logic ref_onoff_o,
  output logic [5:0] chan_current_o,
  output logic [1:0] q_mon_sel_o,
  output logic [1:0] f_mon_sel_o,
  output logic irq_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0] en_sync;
    logic [1:0] sel0_sync;
    logic [1:0] sel1_sync;
    valve_io_pkg::ctrl_type ctrl;
    valve_io_pkg::mode_type mode;
    logic [3:0] irq_mask;
    logic [3:0] irq_stat;
    logic fault_prev;
    logic en_prev;
    logic [1:0] set_prev;
    logic fault_n;
    logic sol_en;
    logic rep_en;
    logic [1:0] pset;
    logic irq;
    valve_io_pkg::bus_state_type bus_st;
    valve_io_pkg::wb_rsp_type rsp;
  } state_type;

  state_type state_ff;
  state_type nxt_state;

  logic any_fault;
  logic ref_broken;
  logic [1:0] set_code;
  logic [1:0] set_dec;
  logic en_level;
  logic [3:0] events;
  logic bus_req;
  logic rd_stat;
  logic [31:0] rd_data;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    // Only the second stage of each synchroniser is read below
    nxt_state.en_sync = {state_ff.en_sync[0], enable_i};
    nxt_state.sel0_sync = {state_ff.sel0_sync[0], param_set_sel_0_i};
    nxt_state.sel1_sync = {state_ff.sel1_sync[0], param_set_sel_1_i};
    en_level = state_ff.en_sync[1];
    // Reference cable break only counts while the flow channel is in current mode
    ref_broken = fault_src_i.ref_cable_broken & state_ff.mode.chan_current[0];
    any_fault = fault_src_i.solenoid_short | fault_src_i.solenoid_open
              | ref_broken | fault_src_i.lvdt_cable_broken;
    if (state_ff.ctrl.fault_as_gpo) begin
      nxt_state.fault_n = state_ff.ctrl.fault_gpo_val;
    end else begin
      nxt_state.fault_n = ~any_fault;
    end
    // Solenoid current needs enable or enable_as_gpi, no broken reference and solenoid power
    nxt_state.sol_en = (en_level | state_ff.mode.enable_as_gpi) & ~ref_broken
                     & solenoid_supply_ok_i;
    nxt_state.rep_en = en_level;
    set_code = {state_ff.sel1_sync[1], state_ff.sel0_sync[1]};
    if (state_ff.ctrl.gray_sel) begin
      set_dec = {set_code[1], set_code[1] ^ set_code[0]};
    end else begin
      set_dec = set_code;
    end
    nxt_state.pset = set_dec;
    nxt_state.fault_prev = any_fault;
    nxt_state.en_prev = en_level;
    nxt_state.set_prev = set_dec;
    events = 4'h0;
    events[valve_io_pkg::IRQ_FAULT_SET] = any_fault & ~state_ff.fault_prev;
    events[valve_io_pkg::IRQ_FAULT_CLR] = ~any_fault & state_ff.fault_prev;
    events[valve_io_pkg::IRQ_ENABLE_CHG] = en_level ^ state_ff.en_prev;
    events[valve_io_pkg::IRQ_SET_CHG] = set_dec != state_ff.set_prev;

    // Wishbone classic slave: one wait state, ack for one cycle
    // The bus stays live whatever the enable level, so software can always diagnose
    bus_req = wb_cyc_i & wb_stb_i;
    rd_stat = 1'b0;
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      valve_io_pkg::CTRL_OFS: rd_data = {24'h00_0000, state_ff.ctrl};
      valve_io_pkg::MODE_OFS: rd_data = {24'h00_0000, state_ff.mode};
      valve_io_pkg::STAT_OFS: begin
        rd_data = {24'h00_0000, state_ff.pset, en_level, ~state_ff.fault_n,
          fault_src_i};
      end
      valve_io_pkg::IRQ_STAT_OFS: begin
        rd_data = {28'h000_0000, state_ff.irq_stat};
        rd_stat = 1'b1;
      end
      valve_io_pkg::IRQ_MASK_OFS: rd_data = {28'h000_0000, state_ff.irq_mask};
      default: rd_data = 32'h0000_0000;
    endcase
    nxt_state.rsp.ack = 1'b0;
    nxt_state.irq_stat = state_ff.irq_stat;
    case (state_ff.bus_st)
      valve_io_pkg::BUS_IDLE: begin
        if (bus_req) begin
          nxt_state.rsp.ack = 1'b1;
          nxt_state.rsp.dat = wb_we_i ? 32'h0000_0000 : rd_data;
          nxt_state.bus_st = valve_io_pkg::BUS_ACK;
          if (wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
              valve_io_pkg::CTRL_OFS: nxt_state.ctrl = wb_dat_i[7:0];
              valve_io_pkg::MODE_OFS: nxt_state.mode = wb_dat_i[7:0];
              valve_io_pkg::IRQ_MASK_OFS: nxt_state.irq_mask = wb_dat_i[3:0];
              default: nxt_state.irq_mask = state_ff.irq_mask;
            endcase
          end else if (!wb_we_i && rd_stat) begin
            nxt_state.irq_stat = 4'h0;
          end
        end
      end
      valve_io_pkg::BUS_ACK: begin
        nxt_state.bus_st = valve_io_pkg::BUS_IDLE;
      end
      default: nxt_state.bus_st = valve_io_pkg::BUS_IDLE;
    endcase
    // A new event wins over a read-clear in the same cycle
    nxt_state.irq_stat = nxt_state.irq_stat | events;
    nxt_state.irq = |(nxt_state.irq_stat & nxt_state.irq_mask);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= '0;
      state_ff.ctrl <= valve_io_pkg::CTRL_RST;
      state_ff.mode <= {valve_io_pkg::MODE_RST[7:6], CHAN_CURRENT_DEFAULT};
      state_ff.irq_mask <= valve_io_pkg::IRQ_MASK_RST;
      state_ff.fault_n <= 1'b1;
      state_ff.bus_st <= valve_io_pkg::BUS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign wb_dat_o = state_ff.rsp.dat;
  assign wb_ack_o = state_ff.rsp.ack;
  assign solenoid_en_o = state_ff.sol_en;
  assign repeat_enable_o = state_ff.rep_en;
  assign fault_n_o = state_ff.fault_n;
  assign param_set_o = state_ff.pset;
  assign enable_gpi_o = state_ff.rep_en;
  assign ref_from_fieldbus_o = state_ff.ctrl.ref_fieldbus;
  assign ref_onoff_o = state_ff.mode.ref_onoff;
  assign chan_current_o = state_ff.mode.chan_current;
  assign q_mon_sel_o = state_ff.ctrl.q_mon_sel;
  assign f_mon_sel_o = state_ff.ctrl.f_mon_sel;
  assign irq_o = state_ff.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_sol_off_disabled: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!state_ff.en_sync[1] && !state_ff.mode.enable_as_gpi) |=> !solenoid_en_o)
    else $error("solenoid on while disabled");
  a_sol_on_enabled: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_ff.en_sync[1] && !ref_broken && solenoid_supply_ok_i) |=> solenoid_en_o)
    else $error("solenoid off while enabled");
  a_gpi_no_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_ff.mode.enable_as_gpi && !ref_broken && solenoid_supply_ok_i)
    |=> solenoid_en_o)
    else $error("enable still gates in gpi mode");
  a_repeat_copy: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> (repeat_enable_o == $past(state_ff.en_sync[1])))
    else $error("repeat enable mismatch");
  a_fault_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (any_fault && !state_ff.ctrl.fault_as_gpo) |=> !fault_n_o)
    else $error("fault output not low");
  a_fault_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!any_fault && !state_ff.ctrl.fault_as_gpo) |=> fault_n_o)
    else $error("fault output not high");
  a_fault_gpo: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_ff.ctrl.fault_as_gpo |=> (fault_n_o == $past(state_ff.ctrl.fault_gpo_val)))
    else $error("fault gpo value wrong");
  a_ref_break_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ref_broken |=> !solenoid_en_o)
    else $error("valve on with broken reference");
  a_set_latency: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $changed(param_set_sel_1_i) && !state_ff.ctrl.gray_sel && $stable(state_ff.ctrl)
    |-> ##3 (param_set_o[1] == $past(param_set_sel_1_i, 3)))
    else $error("set select latency wrong");
  a_gray_decode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_ff.ctrl.gray_sel |=>
    (param_set_o == {$past(set_code[1]), ^$past(set_code)}))
    else $error("gray decode wrong");
  a_pset_binary: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !state_ff.ctrl.gray_sel |=> (param_set_o == $past(set_code)))
    else $error("binary decode wrong");
  a_fault_lvdt: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (fault_src_i.lvdt_cable_broken && !state_ff.ctrl.fault_as_gpo) |=> !fault_n_o)
    else $error("transducer break not flagged");
  a_fault_short: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (fault_src_i.solenoid_short && !state_ff.ctrl.fault_as_gpo) |=> !fault_n_o)
    else $error("solenoid short not flagged");
  a_fault_open: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (fault_src_i.solenoid_open && !state_ff.ctrl.fault_as_gpo) |=> !fault_n_o)
    else $error("solenoid open not flagged");
  a_volt_ref_ok: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (fault_src_i == 4'h2 && !state_ff.mode.chan_current[0]
    && !state_ff.ctrl.fault_as_gpo) |=> fault_n_o)
    else $error("reference break flagged in voltage mode");
  a_supply_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !solenoid_supply_ok_i |=> !solenoid_en_o)
    else $error("solenoid on without power");

  // ****************************************************************
  // Bus, interrupt and fault-gating assertions
  // ****************************************************************
  // Ack is a single pulse; a master that holds stb past the ack cycle is acked and commits again two cycles on
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_after_req: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (bus_req && state_ff.bus_st == valve_io_pkg::BUS_IDLE) |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_needs_req: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!bus_req || state_ff.bus_st != valve_io_pkg::BUS_IDLE) |=> !wb_ack_o)
    else $error("ack without request");
  a_write_ctrl: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (bus_req && state_ff.bus_st == valve_io_pkg::BUS_IDLE && wb_we_i && wb_sel_i[0]
    && wb_adr_i == valve_io_pkg::CTRL_OFS) |=> (state_ff.ctrl == $past(wb_dat_i[7:0])))
    else $error("control write lost");
  a_write_mode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (bus_req && state_ff.bus_st == valve_io_pkg::BUS_IDLE && wb_we_i && wb_sel_i[0]
    && wb_adr_i == valve_io_pkg::MODE_OFS) |=> (state_ff.mode == $past(wb_dat_i[7:0])))
    else $error("mode write lost");
  a_sel_masked: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (bus_req && wb_we_i && !wb_sel_i[0]) |=>
    ($stable(state_ff.ctrl) && $stable(state_ff.mode) && $stable(state_ff.irq_mask)))
    else $error("masked write took effect");
  a_read_ctrl: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (bus_req && state_ff.bus_st == valve_io_pkg::BUS_IDLE && !wb_we_i
    && wb_adr_i == valve_io_pkg::CTRL_OFS) |=> (wb_dat_o == {24'h00_0000, $past(state_ff.ctrl)}))
    else $error("control read wrong");
  a_write_dat_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (bus_req && state_ff.bus_st == valve_io_pkg::BUS_IDLE && wb_we_i)
    |=> (wb_dat_o == 32'h0000_0000))
    else $error("write returned data");
  // A fault edge in the read-clear cycle must not be lost
  a_set_wins: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    events[valve_io_pkg::IRQ_FAULT_SET] |=> state_ff.irq_stat[valve_io_pkg::IRQ_FAULT_SET])
    else $error("fault event lost");
  a_read_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (bus_req && state_ff.bus_st == valve_io_pkg::BUS_IDLE && !wb_we_i && rd_stat
    && events == 4'h0) |=> (state_ff.irq_stat == 4'h0))
    else $error("status not cleared by read");
  a_irq_level: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_o == |(state_ff.irq_stat & state_ff.irq_mask))
    else $error("interrupt level wrong");
  a_fault_no_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!state_ff.en_sync[1] && any_fault && !state_ff.ctrl.fault_as_gpo) |=> !fault_n_o)
    else $error("fault hidden by disable");

endmodule : valve_driver_discrete_io

// ==== mcu_model.sv ====
// Model of the machine control unit that drives the discrete inputs
`timescale 1ns/1ps
module mcu_model (
  input wire logic clk_i,
  input wire logic [6:0] want_i,
  output logic enable_o,
  output logic sel_0_o,
  output logic sel_1_o,
  output valve_io_pkg::fault_src_type fault_src_o
);
  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Levels start low so nothing reaches the block undriven
  initial begin
    enable_o = 1'b0;
    sel_0_o = 1'b0;
    sel_1_o = 1'b0;
    fault_src_o = 4'h0;
  end
  always @(posedge clk_i) begin
    enable_o <= want_i[6];
    sel_1_o <= want_i[5];
    sel_0_o <= want_i[4];
    fault_src_o <= want_i[3:0];
  end
endmodule : mcu_model

// ==== tb_valve_driver_discrete_io.sv ====
// Self-checking bench for the valve discrete I/O block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_valve_driver_discrete_io;
  localparam logic [5:0] CUR_DEF = 6'h01;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic solenoid_supply_ok_i = 1'b1;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, enable_i, param_set_sel_0_i, param_set_sel_1_i, solenoid_en_o;
  logic repeat_enable_o, fault_n_o, enable_gpi_o, ref_from_fieldbus_o, ref_onoff_o, irq_o;
  logic [1:0] param_set_o, q_mon_sel_o, f_mon_sel_o;
  logic [5:0] chan_current_o;
  logic [7:0] c, m;
  logic [6:0] want = 7'h00;
  logic [6:0] w;
  valve_io_pkg::fault_src_type fault_src_i;
  int err_total = 0;
  int n_compared = 0;
  int seed;

  valve_driver_discrete_io #(.CHAN_CURRENT_DEFAULT(CUR_DEF)) dut_u (.clk_i, .sys_rst_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .enable_i, .param_set_sel_0_i, .param_set_sel_1_i, .fault_src_i, .solenoid_supply_ok_i,
    .solenoid_en_o, .repeat_enable_o, .fault_n_o, .param_set_o, .enable_gpi_o,
    .ref_from_fieldbus_o, .ref_onoff_o, .chan_current_o, .q_mon_sel_o, .f_mon_sel_o, .irq_o);
  mcu_model mcu_u (.clk_i(clk_i), .want_i(want), .enable_o(enable_i),
    .sel_0_o(param_set_sel_0_i), .sel_1_o(param_set_sel_1_i), .fault_src_o(fault_src_i));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Tasks and expectations
  // ****************************************************************
  task automatic wrap_up();
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // Request held until ack is seen; the bound stands in for a hung slave
  task automatic xfer(input logic [7:0] a, input logic we, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) begin
      err_total++;
      wrap_up();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, {24'h0, d});
    tick(2);
  endtask : wr
  task automatic pins(input logic [6:0] v);
    @(posedge clk_i);
    want <= v;
    tick(6);
  endtask : pins
  function automatic logic [1:0] set_of(input logic s1, input logic s0, input logic g);
    return g ? {s1, s1 ^ s0} : {s1, s0};
  endfunction : set_of
  function automatic logic fault_of(input logic [3:0] f, input logic cur);
    return f[3] | f[2] | f[0] | (f[1] & cur);
  endfunction : fault_of

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32'h2cb7becd;
    tick(3);
    sys_rst_i <= 1'b0;
    tick(1);
    `CHK(fault_n_o, 1'b1)
    `CHK(solenoid_en_o, 1'b0)
    xfer(valve_io_pkg::MODE_OFS, 1'b0, 32'h0);
    `CHK(q, {26'h0, CUR_DEF})
    xfer(8'h40, 1'b1, 32'hff);
    xfer(8'h40, 1'b0, 32'h0);
    `CHK(q, 32'h0)
    for (int k = 0; k < 8; k++) begin
      c = 8'($random(seed)) & 8'hf8;
      m = 8'($random(seed)) & 8'hbf;
      wr(valve_io_pkg::CTRL_OFS, c);
      wr(valve_io_pkg::MODE_OFS, m);
      `CHK({f_mon_sel_o, q_mon_sel_o}, c[7:4])
      `CHK(ref_from_fieldbus_o, c[3])
      `CHK(ref_onoff_o, m[7])
      `CHK(chan_current_o, m[5:0])
      xfer(valve_io_pkg::CTRL_OFS, 1'b0, 32'h0);
      `CHK(q, {24'h0, c})
    end
    wr(valve_io_pkg::CTRL_OFS, 8'h00);
    wr(valve_io_pkg::MODE_OFS, {2'b00, CUR_DEF});
    pins(7'h40);
    `CHK(solenoid_en_o, 1'b1)
    `CHK(repeat_enable_o, 1'b1)
    pins(7'h00);
    `CHK(solenoid_en_o, 1'b0)
    `CHK(repeat_enable_o, 1'b0)
    xfer(valve_io_pkg::STAT_OFS, 1'b0, 32'h0);
    `CHK(q[5:4], 2'b00)
    wr(valve_io_pkg::MODE_OFS, {2'b01, CUR_DEF});
    `CHK(solenoid_en_o, 1'b1)
    pins(7'h40);
    `CHK(enable_gpi_o, 1'b1)
    wr(valve_io_pkg::MODE_OFS, {2'b00, CUR_DEF});
    for (int k = 0; k < 24; k++) begin
      w = 7'($random(seed)) & 7'h4f;
      if (k < 16) w[3:0] = 4'(k);
      pins(w);
      `CHK(fault_n_o, ~fault_of(w[3:0], CUR_DEF[0]))
      if (w[3:0] == 4'h2 || w[3:0] == 4'h0) `CHK(solenoid_en_o, w[6] & ~w[1])
    end
    wr(valve_io_pkg::MODE_OFS, 8'h00);
    pins(7'h42);
    `CHK(fault_n_o, 1'b1)
    `CHK(solenoid_en_o, 1'b1)
    pins(7'h48);
    wr(valve_io_pkg::CTRL_OFS, 8'h03);
    `CHK(fault_n_o, 1'b1)
    pins(7'h40);
    wr(valve_io_pkg::CTRL_OFS, 8'h01);
    `CHK(fault_n_o, 1'b0)
    for (int k = 0; k < 8; k++) begin
      wr(valve_io_pkg::CTRL_OFS, {5'h0, k[2], 2'b00});
      pins({1'b1, k[1], k[0], 4'h0});
      `CHK(param_set_o, set_of(k[1], k[0], k[2]))
      `CHK(solenoid_en_o, 1'b1)
    end
    wr(valve_io_pkg::CTRL_OFS, 8'h00);
    pins(7'h40);
    xfer(valve_io_pkg::IRQ_STAT_OFS, 1'b0, 32'h0);
    wr(valve_io_pkg::IRQ_MASK_OFS, 8'h01);
    `CHK(irq_o, 1'b0)
    pins(7'h41);
    `CHK(irq_o, 1'b1)
    xfer(valve_io_pkg::IRQ_STAT_OFS, 1'b0, 32'h0);
    `CHK(q[0], 1'b1)
    tick(3);
    `CHK(irq_o, 1'b0)
    pins(7'h40);
    `CHK(irq_o, 1'b0)
    solenoid_supply_ok_i <= 1'b0;
    pins(7'h41);
    xfer(valve_io_pkg::STAT_OFS, 1'b0, 32'h0);
    `CHK(q[5:4], 2'b11)
    `CHK(solenoid_en_o, 1'b0)
    wrap_up();
  end
endmodule : tb_valve_driver_discrete_io
